/* File: pkg/cmrg_defines.vh */
`ifndef CMRG_DEFINES_VH
`define CMRG_DEFINES_VH

// Controller crystal and internal scratch memory size.
`define CMRG_XTAL_KHZ 5856
`define CMRG_SCRATCH_BYTES 128
`define CMRG_BUS_W 8
`define CMRG_RAM_DATA_W 4
`define CMRG_UPPER_W 4

// System clock period in picoseconds (125 MHz).
`define CMRG_CLK_PS 8000

// Watchdog timeout in milliseconds.
`define CMRG_WDOG_MS 1300
// Nominal latch strobe rate in kHz, one strobe every fifteen crystal cycles.
`define CMRG_ALE_KHZ 390
// Terminal count of latch strobes: ms * kHz.
`define CMRG_WDOG_COUNT (`CMRG_WDOG_MS * `CMRG_ALE_KHZ)

// Reset release delay (charging time) in microseconds.
`define CMRG_CHARGE_US 10000
// Cycles per microsecond first, so the product stays inside 32 bits.
`define CMRG_CHARGE_CYC (`CMRG_CHARGE_US * (1000000 / `CMRG_CLK_PS))

`endif

/* File: test/cmrg_glue_assertions.sv */
`timescale 1ns/1ps
module cmrg_glue_chk #(
    parameter CHARGE_CYC = 8
) (
    // Clock, reset and supply.
    input wire ref_clk_in,
    input wire rst_in,
    input wire supply_good_in,
    // Controller side.
    input wire cal_unlock_in,
    input wire port2_bit6_in,
    input wire [3:0] upper_port_lines_in,
    // Outputs under watch.
    input wire ctrl_reset_n_out,
    input wire single_step_n_out,
    input wire reset_request_out,
    input wire [12:0] rom_addr_out,
    input wire rom_chip_enable_n_out,
    input wire ram_power_gate_out,
    input wire ram_write_n_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    // Counts cycles spent in reset so the release delay can be bounded.
    reg [21:0] low_q;
    wire [21:0] low_d = ctrl_reset_n_out ? 22'h0 : low_q + 22'h1;
    always @(posedge ref_clk_in or posedge rst_in)
        if (rst_in) low_q <= 22'h0;
        else low_q <= low_d;
    sequence s_locked;
        !cal_unlock_in [*5];
    endsequence
    sequence s_parked;
        !ctrl_reset_n_out [*3];
    endsequence
    a_gate_follows_reset: assert property (
        ram_power_gate_out == ctrl_reset_n_out) else $error("gate mismatch");
    a_step_in_reset: assert property (
        !ctrl_reset_n_out |-> !single_step_n_out && rom_chip_enable_n_out)
        else $error("step or rom active in reset");
    a_supply_low_reset: assert property (
        !supply_good_in [*4] |-> !ctrl_reset_n_out && !ram_power_gate_out)
        else $error("supply low without reset");
    a_request_resets: assert property (
        $rose(reset_request_out) |-> ##[0:1] !ctrl_reset_n_out)
        else $error("request did not reset");
    a_request_drops: assert property (
        s_parked |-> !reset_request_out) else $error("request stuck");
    a_write_locked: assert property (
        s_locked |-> ram_write_n_out) else $error("write while locked");
    a_rom_upper: assert property (
        $stable({port2_bit6_in, upper_port_lines_in}) [*3] |->
        rom_addr_out[12:8] == {port2_bit6_in, upper_port_lines_in})
        else $error("upper rom address wrong");
    a_release_delay: assert property (
        $rose(ctrl_reset_n_out) |-> $past(low_q) + 22'h1 >= CHARGE_CYC)
        else $error("reset released early");
endmodule // cmrg_glue_chk
bind cmrg_glue cmrg_glue_chk #(.CHARGE_CYC(CHARGE_CYC)) cmrg_glue_chk_i (.*);

/* File: test/cmrg_mem_model.sv */
`timescale 1ns/1ps
module cmrg_mem_model (
    // Clock.
    input wire ref_clk_in,
    // Program ROM.
    input wire [12:0] rom_addr_in,
    input wire rom_chip_enable_n_in,
    output wire [7:0] rom_data_out,
    // Calibration RAM.
    input wire [7:0] ram_addr_in,
    input wire ram_select_n_in,
    input wire ram_power_gate_in,
    input wire ram_output_disable_in,
    input wire ram_write_n_in,
    input wire [3:0] ram_wdata_in,
    output wire [3:0] ram_rdata_out
);
    reg [3:0] mem [0:255];
    wire ram_on = ram_power_gate_in && !ram_select_n_in;
    wire ram_off = !ram_on || ram_output_disable_in;
    // Released lines show inverted data so stale values never look valid.
    assign rom_data_out = rom_addr_in[7:0] ^ {8{rom_chip_enable_n_in}};
    assign ram_rdata_out = mem[ram_addr_in] ^ {4{ram_off}};
    always @(posedge ref_clk_in) begin
        if (ram_on && !ram_write_n_in) begin
            mem[ram_addr_in] <= ram_wdata_in;
        end
    end
endmodule // cmrg_mem_model

/* File: test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    reg ref_clk_in = 1'h0;
    reg rst_in = 1'h1;
    reg supply_good_in = 1'h1;
    reg cal_unlock_in = 1'h0;
    reg addr_latch_strobe_in = 1'h0;
    reg program_fetch_strobe_n_in = 1'h1;
    reg read_strobe_n_in = 1'h1;
    reg write_strobe_n_in = 1'h1;
    reg port2_bit6_in = 1'h0;
    reg select_port_bit_in = 1'h1;
    reg scan_port_line_in = 1'h0;
    reg [7:0] ad_bus_in = 8'h00;
    reg [3:0] upper_port_lines_in = 4'h0;
    wire ctrl_reset_n_out, single_step_n_out, reset_request_out;
    wire rom_chip_enable_n_out, ram_select_n_out, ram_power_gate_out;
    wire ram_output_disable_out, ram_write_n_out, bus_rdata_oe_out;
    wire [12:0] rom_addr_out;
    wire [7:0] rom_data_in, ram_addr_out, bus_rdata_out;
    wire [3:0] ram_wdata_out, ram_rdata_in;
    integer num_errors = 0;
    integer comparisons = 0;
    integer cycles = 0;
    reg seen_req = 1'h0;
    cmrg_glue #(.WDOG_COUNT(16), .CHARGE_CYC(8)) cmrg_glue_i (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .supply_good_in(supply_good_in), .cal_unlock_in(cal_unlock_in),
        .ad_bus_in(ad_bus_in), .addr_latch_strobe_in(addr_latch_strobe_in),
        .program_fetch_strobe_n_in(program_fetch_strobe_n_in),
        .read_strobe_n_in(read_strobe_n_in),
        .write_strobe_n_in(write_strobe_n_in),
        .upper_port_lines_in(upper_port_lines_in),
        .port2_bit6_in(port2_bit6_in),
        .select_port_bit_in(select_port_bit_in),
        .scan_port_line_in(scan_port_line_in),
        .ctrl_reset_n_out(ctrl_reset_n_out),
        .single_step_n_out(single_step_n_out),
        .reset_request_out(reset_request_out),
        .rom_addr_out(rom_addr_out),
        .rom_chip_enable_n_out(rom_chip_enable_n_out),
        .rom_data_in(rom_data_in), .ram_addr_out(ram_addr_out),
        .ram_select_n_out(ram_select_n_out),
        .ram_power_gate_out(ram_power_gate_out),
        .ram_output_disable_out(ram_output_disable_out),
        .ram_write_n_out(ram_write_n_out), .ram_wdata_out(ram_wdata_out),
        .ram_rdata_in(ram_rdata_in), .bus_rdata_out(bus_rdata_out),
        .bus_rdata_oe_out(bus_rdata_oe_out));
    cmrg_mem_model cmrg_mem_model_i (
        .ref_clk_in(ref_clk_in), .rom_addr_in(rom_addr_out),
        .rom_chip_enable_n_in(rom_chip_enable_n_out),
        .rom_data_out(rom_data_in), .ram_addr_in(ram_addr_out),
        .ram_select_n_in(ram_select_n_out),
        .ram_power_gate_in(ram_power_gate_out),
        .ram_output_disable_in(ram_output_disable_out),
        .ram_write_n_in(ram_write_n_out), .ram_wdata_in(ram_wdata_out),
        .ram_rdata_out(ram_rdata_in));
    always #4 ref_clk_in = ~ref_clk_in;
    ////////////////////////////////////////////////////////////////////////
    task stop_test;
        begin
            $display("errors %0d comparisons %0d", num_errors, comparisons);
            if (num_errors == 0 && comparisons > 0) begin
                $display("All tests passed");
            end else begin
                $display("Some tests failed");
            end
            $finish;
        end
    endtask
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        seen_req <= seen_req | reset_request_out;
        if (cycles == 5000) begin
            num_errors = num_errors + 1;
            stop_test;
        end
    end
    // Callers compare at the falling edge, where the outputs have settled.
    task chk(input [15:0] seen, input [15:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                num_errors = num_errors + 1;
                $display("unexpected at %0t: %h not %h", $time, seen, exp);
            end
        end
    endtask
    task tick(input integer n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    // A controller bus cycle; the strobe stops while the controller is reset.
    task cyc(input [7:0] a, input [7:0] d, input r, input w, input [7:0] e);
        begin
            addr_latch_strobe_in <= ctrl_reset_n_out;
            ad_bus_in <= a;
            tick(4);
            addr_latch_strobe_in <= 1'h0;
            tick(4);
            ad_bus_in <= d;
            read_strobe_n_in <= !r;
            write_strobe_n_in <= !w;
            tick(6);
            @(negedge ref_clk_in);
            if (r) chk({bus_rdata_oe_out, ram_output_disable_out,
                        bus_rdata_out}, {2'h2, e});
            tick(1);
            read_strobe_n_in <= 1'h1;
            write_strobe_n_in <= 1'h1;
            tick(2);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        tick(12);
        rst_in <= 1'h0;
        tick(4);
        @(negedge ref_clk_in);
        chk({ctrl_reset_n_out, ram_power_gate_out}, 2'h0);
        tick(20);
        @(negedge ref_clk_in);
        chk({ctrl_reset_n_out, single_step_n_out}, 2'h3);
        $display("test power_up done");
        tick(1);
        upper_port_lines_in <= 4'hA;
        port2_bit6_in <= 1'h1;
        cyc(8'h3C, 8'h00, 1'h0, 1'h0, 8'h00);
        program_fetch_strobe_n_in <= 1'h0;
        tick(4);
        @(negedge ref_clk_in);
        chk({rom_chip_enable_n_out, rom_addr_out}, 14'h1A3C);
        tick(1);
        program_fetch_strobe_n_in <= 1'h1;
        $display("test rom_fetch done");
        select_port_bit_in <= 1'h0;
        cal_unlock_in <= 1'h1;
        cyc(8'h21, 8'hF6, 1'h0, 1'h1, 8'h00);
        cal_unlock_in <= 1'h0;
        cyc(8'h21, 8'h05, 1'h0, 1'h1, 8'h00);
        @(negedge ref_clk_in);
        chk({ram_select_n_out, ram_addr_out}, 9'h021);
        tick(1);
        cyc(8'h21, 8'h00, 1'h1, 1'h0, 8'h06);
        $display("test ram_access done");
        repeat (40) begin
            scan_port_line_in <= ~scan_port_line_in;
            cyc(8'h00, 8'h00, 1'h0, 1'h0, 8'h00);
        end
        @(negedge ref_clk_in);
        chk({seen_req, ctrl_reset_n_out}, 2'h1);
        tick(1);
        repeat (14) cyc(8'h00, 8'h00, 1'h0, 1'h0, 8'h00);
        @(negedge ref_clk_in);
        chk(seen_req, 1'h0);
        tick(1);
        repeat (10) cyc(8'h00, 8'h00, 1'h0, 1'h0, 8'h00);
        @(negedge ref_clk_in);
        chk(seen_req, 1'h1);
        tick(30);
        @(negedge ref_clk_in);
        chk({reset_request_out, ctrl_reset_n_out}, 2'h1);
        $display("test watchdog done");
        tick(1);
        supply_good_in <= 1'h0;
        cal_unlock_in <= 1'h1;
        tick(4);
        @(negedge ref_clk_in);
        chk({ctrl_reset_n_out, ram_power_gate_out}, 2'h0);
        tick(1);
        cyc(8'h21, 8'h0F, 1'h0, 1'h1, 8'h00);
        supply_good_in <= 1'h1;
        cal_unlock_in <= 1'h0;
        tick(30);
        cyc(8'h21, 8'h00, 1'h1, 1'h0, 8'h06);
        $display("test supply_loss done");
        stop_test;
    end
endmodule // tb_top

/* File: verilog/cmrg_edge.v */
`timescale 1ns/1ps

// Rising edge detector on a synchronised level; one-cycle pulse out.
module cmrg_edge (
    // Clock and reset.
    input wire ref_clk_in,
    input wire rst_in,
    // Level and pulse.
    input wire level_in,
    output wire rise_out
);

reg prev_q;

always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
        prev_q <= 1'b0;
    end else begin
        prev_q <= level_in;
    end
end

assign rise_out = level_in & ~prev_q;

endmodule // cmrg_edge

/* File: verilog/cmrg_glue.v */
`timescale 1ns/1ps
`include "cmrg_defines.vh"

// Behaviour
// [R1] Clock from crystal; 128-byte scratch memory.
// [R2] Bus carries low address then data.
// [R3] Latch low address byte on strobe fall.
// [R4] Display port lines supply address bits 8-11.
// [R5] Port two bit six drives address 12.
// [R6] Fetch strobe directly enables program ROM.
// [R7] Reset held until charge timer after power.
// [R8] Supply low forces reset immediately.
// [R9] Single-step held low during reset.
// [R10] RAM power gate low during reset.
// [R11] Watchdog counts every latch strobe.
// [R12] Scan pulse edge clears watchdog counter.
// [R13] Unscanned watchdog expires, raises reset request.
// [R14] Reset request pulls controller reset low.
// [R15] Reset stops strobe; request drops; recharge.
// [R16] RAM accessible only while power gate high.
// [R17] RAM drives bus on read, select, gate.
// [R18] RAM select latched from port bit each strobe.
// [R19] RAM uses latched address, bus bits 0-3.
// [R20] RAM write only with unlock switch on.
// [R21] RAM disabled when power removed.
// [R22] Power gate drops before supply collapses.
// [R23] Firmware raises four scan lines in sequence.
// [R24] Watchdog timeout is a strobe terminal count.
// [R25] Release delay is a synchronous counter.
module cmrg_glue #(
    parameter WDOG_COUNT = `CMRG_WDOG_COUNT,
    parameter CHARGE_CYC = `CMRG_CHARGE_CYC,
    parameter WDOG_W = 20,
    parameter CHARGE_W = 21
) (
    // Clock and reset.
    input wire ref_clk_in,
    input wire rst_in,
    // Supply monitor and front panel.
    input wire supply_good_in,
    input wire cal_unlock_in,
    // Controller bus, from controller pins.
    input wire [7:0] ad_bus_in,
    input wire addr_latch_strobe_in,
    input wire program_fetch_strobe_n_in,
    input wire read_strobe_n_in,
    input wire write_strobe_n_in,
    input wire [3:0] upper_port_lines_in,
    input wire port2_bit6_in,
    input wire select_port_bit_in,
    input wire scan_port_line_in,
    // Controller reset and single step.
    output wire ctrl_reset_n_out,
    output wire single_step_n_out,
    output wire reset_request_out,
    // Program ROM side.
    output wire [12:0] rom_addr_out,
    output wire rom_chip_enable_n_out,
    input wire [7:0] rom_data_in,
    // Calibration RAM side.
    output wire [7:0] ram_addr_out,
    output wire ram_select_n_out,
    output wire ram_power_gate_out,
    output wire ram_output_disable_out,
    output wire ram_write_n_out,
    output wire [3:0] ram_wdata_out,
    input wire [3:0] ram_rdata_in,
    // Read data returned onto the controller bus.
    output wire [7:0] bus_rdata_out,
    output wire bus_rdata_oe_out
);

////////////////////////////////////////////////////////////////////////
// Pin synchronisation.

wire [7:0] ad_s;
wire [3:0] upper_s;
wire [3:0] strobe_s;
wire [4:0] ctl_s;
wire ale_s;
wire fetch_n_s;
wire rd_n_s;
wire wr_n_s;
wire p26_s;
wire sel_s;
wire scan_s;
wire sup_s;
wire unlock_s;
wire ale_fall_raw;
wire ale_fall;
wire ale_rise;
wire scan_rise;
reg ale_armed_q;

// The bus lines have no idle level worth keeping, so they clear to zero.
cmrg_sync #(.W(8), .INIT(8'h00)) u_sync_ad (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .d_in(ad_bus_in),
    .q_out(ad_s)
);

cmrg_sync #(.W(4), .INIT(4'h0)) u_sync_up (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .d_in(upper_port_lines_in),
    .q_out(upper_s)
);

// Low-active strobes start at their idle high level, the latch strobe low.
cmrg_sync #(.W(4), .INIT(4'hE)) u_sync_strb (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .d_in({write_strobe_n_in, read_strobe_n_in,
           program_fetch_strobe_n_in, addr_latch_strobe_in}),
    .q_out(strobe_s)
);

// Supply is taken as bad and the RAM select as inactive until seen.
cmrg_sync #(.W(5), .INIT(5'h02)) u_sync_ctl (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .d_in({cal_unlock_in, supply_good_in, scan_port_line_in,
           select_port_bit_in, port2_bit6_in}),
    .q_out(ctl_s)
);

assign ale_s = strobe_s[0];
assign fetch_n_s = strobe_s[1];
assign rd_n_s = strobe_s[2];
assign wr_n_s = strobe_s[3];
assign p26_s = ctl_s[0];
assign sel_s = ctl_s[1];
assign scan_s = ctl_s[2];
assign sup_s = ctl_s[3];
assign unlock_s = ctl_s[4];

cmrg_edge u_ale_rise (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .level_in(ale_s),
    .rise_out(ale_rise)
);

cmrg_edge u_ale_fall (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .level_in(~ale_s),
    .rise_out(ale_fall_raw)
);

// A fall is only believed once the strobe has been seen high, so the
// detector's reset state cannot fake an address latch right after reset.
always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
        ale_armed_q <= 1'b0;
    end else begin
        if (ale_rise) begin
            ale_armed_q <= 1'b1;
        end
    end
end

assign ale_fall = ale_fall_raw & ale_armed_q;

// The scan line only clears the counter on its edge, so a line stuck high
// cannot hold the watchdog off forever.
cmrg_edge u_scan_rise (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .level_in(scan_s),
    .rise_out(scan_rise)
);

////////////////////////////////////////////////////////////////////////
// Address demultiplex and RAM select latch.

reg [7:0] addr_lo_q;
reg ram_sel_n_q;

always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
        addr_lo_q <= 8'h00;
        ram_sel_n_q <= 1'b1;
    end else begin
        if (ale_fall) begin
            addr_lo_q <= ad_s; // [R2] [R3]
            ram_sel_n_q <= sel_s; // [R18]
        end
    end
end

////////////////////////////////////////////////////////////////////////
// Power-on, watchdog and reset release.

reg [WDOG_W-1:0] wdog_q;
reg req_q;
reg [CHARGE_W-1:0] charge_q;
reg reset_n_q;
wire reset_n_d;

// The count only advances on strobe rises, so the timeout scales with the
// controller's strobe rate; a stalled strobe also stalls the watchdog.
// A scan edge in the same cycle as the terminal strobe wins and clears.
always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
        wdog_q <= {WDOG_W{1'b0}};
        req_q <= 1'b0;
    end else begin
        if (!reset_n_q || scan_rise) begin
            // Strobes stop during reset, so the count halts and drops.
            wdog_q <= {WDOG_W{1'b0}}; // [R12] [R15]
            req_q <= 1'b0; // [R15]
        end else if (ale_rise) begin
            if (wdog_q == WDOG_COUNT[WDOG_W-1:0] - 1'b1) begin
                req_q <= 1'b1; // [R13] [R24]
            end else begin
                wdog_q <= wdog_q + 1'b1; // [R11]
            end
        end
    end
end

// Charging timer restarts whenever reset is forced.
// A supply dip shorter than the timer still costs a full release delay,
// which trades a slower restart for never running on a sagging rail.
always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
        charge_q <= {CHARGE_W{1'b0}};
    end else begin
        if (!sup_s || req_q) begin
            charge_q <= {CHARGE_W{1'b0}}; // [R8] [R14]
        end else if (charge_q != CHARGE_CYC[CHARGE_W-1:0]) begin
            charge_q <= charge_q + 1'b1; // [R7] [R25]
        end
    end
end

assign reset_n_d = sup_s && !req_q &&
                   (charge_q == CHARGE_CYC[CHARGE_W-1:0]); // [R7] [R15]

always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
        reset_n_q <= 1'b0;
    end else begin
        reset_n_q <= reset_n_d;
    end
end

// Supply loss bypasses the flop so reset and the gate fall at once.
assign ctrl_reset_n_out = reset_n_q & sup_s; // [R8] [R14]
assign single_step_n_out = ctrl_reset_n_out; // [R9]
assign reset_request_out = req_q; // [R13]
// [R1] [R23] Crystal, scratch memory and scanning live in the controller.

////////////////////////////////////////////////////////////////////////
// Program ROM.

assign rom_addr_out = {p26_s, upper_s, addr_lo_q}; // [R4] [R5]
// While in reset the fetch strobe is forced high, deselecting the ROM.
assign rom_chip_enable_n_out = fetch_n_s | ~ctrl_reset_n_out; // [R6] [R9]

////////////////////////////////////////////////////////////////////////
// Calibration RAM.

wire gate;
wire ram_read;
wire rom_read;

assign gate = ctrl_reset_n_out; // [R10] [R16] [R21] [R22]
assign ram_power_gate_out = gate;
assign ram_addr_out = addr_lo_q; // [R19]
assign ram_select_n_out = ram_sel_n_q;
assign ram_output_disable_out = rd_n_s; // [R17]
assign ram_write_n_out = ~(gate && unlock_s && !wr_n_s &&
                           !ram_sel_n_q); // [R20]
assign ram_wdata_out = ad_s[3:0]; // [R19]

// The unlock level is gated with the synchronised write strobe, the RAM select and the power gate, so a
// switch thrown mid-cycle can at worst shorten a write, never start one
// while the controller is held in reset or the supply is failing.

assign ram_read = gate && !rd_n_s && !ram_sel_n_q; // [R17]
assign rom_read = !rom_chip_enable_n_out;

// Read data is registered; the outer bus mux uses the enable one cycle
// after the strobe, which costs a cycle of latency but avoids glitches.
reg [7:0] rdata_q;
reg rdata_oe_q;

always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
        rdata_q <= 8'h00;
        rdata_oe_q <= 1'b0;
    end else begin
        rdata_oe_q <= ram_read || rom_read;
        if (rom_read) begin
            rdata_q <= rom_data_in; // [R6]
        end else if (ram_read) begin
            rdata_q <= {4'h0, ram_rdata_in}; // [R19]
        end
    end
end

assign bus_rdata_out = rdata_q;
assign bus_rdata_oe_out = rdata_oe_q;

endmodule // cmrg_glue

/* File: verilog/cmrg_sync.v */
`timescale 1ns/1ps

// Two flip-flop synchroniser for asynchronous pin levels.
module cmrg_sync #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    // Clock and reset.
    input wire ref_clk_in,
    input wire rst_in,
    // Levels.
    input wire [W-1:0] d_in,
    output wire [W-1:0] q_out
);

reg [W-1:0] meta_q;
reg [W-1:0] sync_q;

always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
        meta_q <= INIT;
        sync_q <= INIT;
    end else begin
        meta_q <= d_in;
        sync_q <= meta_q;
    end
end

assign q_out = sync_q;

endmodule // cmrg_sync
